// >>> rtl/erb_core.sv
// exception flags, channels, pin routing and strobe bindings
module erb_core
    import erb_pkg::*;
#(
    parameter int unsigned NOLOCK_CYC = `ERB_NOLOCK_NS / `ERB_CLK_PERIOD_NS
)(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic spi_clk,
    input wire logic chip_select_n,
    input wire logic [14:0] exc_low_event,
    input wire logic hp_done,
    input wire logic hp_failed,
    input wire logic bad_addr_hit,
    input wire logic ctx_violation,
    input wire logic fixed_len_instr,
    input wire erb_pkg::erb_byte_t operand_bytes,
    input wire logic in_receive,
    input wire logic synth_lock,
    input wire logic rx_abort,
    input wire logic rx_move_start,
    input wire logic rx_move_short,
    input wire erb_pkg::erb_byte_t receive_move_wait_setting,
    input wire logic flag_wr_en,
    input wire logic [1:0] flag_wr_sel,
    input wire erb_pkg::erb_byte_t flag_wr_data,
    input wire erb_pkg::erb_flag_t mask_a,
    input wire erb_pkg::erb_flag_t mask_b,
    input wire logic [47:0] pin_config_reg,
    input wire logic [15:0] binding_x_regs,
    input wire logic [15:0] binding_y_regs,
    input wire logic host_strobe_req,
    input wire erb_pkg::erb_byte_t host_strobe_code,
    output logic [23:0] exception_flag_regs,
    output logic [5:0] gpio_out,
    output logic [1:0] status_chan,
    output logic exec_valid,
    output logic [7:0] exec_code,
    output logic instr_abort
);
    import erb_pkg::*;

    localparam int unsigned MOVE_UNIT_CYC = `ERB_MOVE_UNIT_NS / `ERB_CLK_PERIOD_NS;

    erb_core_s s;
    erb_core_s next_s;
    erb_flag_t ev;
    erb_flag_t rise;
    erb_flag_t clr;
    logic cs_rise;
    logic hit_x;
    logic hit_y;
    logic take_x;
    logic take_y;

    erb_link_if lk ();

    erb_link_mon u_link (
        .spi_clk(spi_clk),
        .rst_n(rst_n),
        .chip_select_n(chip_select_n),
        .lk(lk.link)
    );

    // --------------------------------
    // helpers
    // --------------------------------
    function automatic logic chan_hit(input erb_flag_t f, input erb_flag_t m);
        chan_hit = |(f & m);
    endfunction

    function automatic logic pin_route(input erb_byte_t code, input erb_flag_t f,
                                       input erb_flag_t ma, input erb_flag_t mb);
        logic r;
        r = 1'b0;
        if (code >= `ERB_CFG_EXC_LO && code <= `ERB_CFG_EXC_HI) begin
            r = f[5'(code - `ERB_CFG_OFS)];
        end else begin
            case (code)
                `ERB_CFG_CH_A: r = chan_hit(f, ma);
                `ERB_CFG_CH_B: r = chan_hit(f, mb);
                `ERB_CFG_NCH_A: r = chan_hit(f, ~ma);
                `ERB_CFG_NCH_B: r = chan_hit(f, ~mb);
                `ERB_CFG_RX_ERR: r = f[`ERB_EXC_RX_UNDF] | f[`ERB_EXC_RX_OVF]
                                   | f[`ERB_EXC_RX_ABORT] | f[`ERB_EXC_MOVE_TO];
                `ERB_CFG_GEN_ERR: r = f[`ERB_EXC_BAD_ADDR] | f[`ERB_EXC_CTX]
                                    | f[`ERB_EXC_OPERAND] | f[`ERB_EXC_SPI];
                default: r = 1'b0;
            endcase
        end
        return r;
    endfunction

    function automatic logic bind_hit(input logic [15:0] b, input erb_flag_t r);
        logic [4:0] idx;
        idx = b[`ERB_BIND_EXC_HI:`ERB_BIND_EXC_LO];
        return b[`ERB_BIND_EN] && idx < 5'(`ERB_NFLAG) && r[idx];
    endfunction

    // --------------------------------
    // next state
    // --------------------------------
    always_comb begin
        next_s = s;
        next_s.cs_s1 = chip_select_n;
        next_s.cs_s2 = s.cs_s1;
        next_s.cs_prev = s.cs_s2;
        cs_rise = s.cs_s2 & ~s.cs_prev;
        next_s.lock_prev = synth_lock;
        next_s.rx_prev = in_receive;

        ev = '0;
        ev[14:0] = exc_low_event;
        ev[`ERB_EXC_HP_DONE] = hp_done & ~hp_failed;
        ev[`ERB_EXC_BAD_ADDR] = bad_addr_hit;
        ev[`ERB_EXC_CTX] = ctx_violation;
        ev[`ERB_EXC_SPI] = cs_rise & lk.mid_byte;
        ev[`ERB_EXC_OPERAND] = cs_rise & ~lk.mid_byte & fixed_len_instr
                             & (lk.byte_cnt != 8'h00)
                             & (lk.byte_cnt < operand_bytes);
        ev[`ERB_EXC_RX_ABORT] = rx_abort & ~exc_low_event[`ERB_EXC_RX_OVF];

        // lock watchdog after entering receive
        if (in_receive & ~s.rx_prev) begin
            next_s.nl_run = 1'b1;
            next_s.nl_cnt = 16'h0000;
        end else if (s.nl_run) begin
            if (synth_lock | ~in_receive) begin
                next_s.nl_run = 1'b0;
            end else if (s.nl_cnt == 16'(NOLOCK_CYC - 1)) begin
                next_s.nl_run = 1'b0;
                ev[`ERB_EXC_NOLOCK] = 1'b1;
            end else begin
                next_s.nl_cnt = s.nl_cnt + 16'h0001;
            end
        end
        if (s.lock_prev & ~synth_lock & in_receive) begin
            ev[`ERB_EXC_NOLOCK] = 1'b1;
        end

        // receive move wait
        if (rx_move_start & rx_move_short) begin
            next_s.mv_run = 1'b1;
            next_s.mv_cnt = 16'h0000;
        end else if (s.mv_run) begin
            if (~rx_move_short) begin
                next_s.mv_run = 1'b0;
            end else if (s.mv_cnt >= 16'(receive_move_wait_setting * MOVE_UNIT_CYC)) begin
                next_s.mv_run = 1'b0;
                ev[`ERB_EXC_MOVE_TO] = 1'b1;
            end else begin
                next_s.mv_cnt = s.mv_cnt + 16'h0001;
            end
        end
        ev[`ERB_EXC_RSVD] = 1'b0;

        rise = ev & ~s.ev_prev;
        next_s.ev_prev = ev;

        // host clear: only zeros written clear
        clr = '0;
        if (flag_wr_en) begin
            case (flag_wr_sel)
                2'h0: clr[7:0] = ~flag_wr_data;
                2'h1: clr[15:8] = ~flag_wr_data;
                2'h2: clr[23:16] = ~flag_wr_data;
                default: clr = '0;
            endcase
        end
        next_s.flags = (s.flags & ~clr) | ev;

        // channels and pins
        next_s.chan[0] = chan_hit(next_s.flags, mask_a);
        next_s.chan[1] = chan_hit(next_s.flags, mask_b);
        for (int i = 0; i < `ERB_NPIN; i++) begin
            next_s.gpio[i] = pin_route(pin_config_reg[i*8 +: 8], next_s.flags,
                                       mask_a, mask_b);
        end

        // bindings and instruction triggers
        hit_x = bind_hit(binding_x_regs, rise);
        hit_y = bind_hit(binding_y_regs, rise);
        take_x = 1'b0;
        take_y = 1'b0;
        next_s.exec_valid = 1'b0;
        if (host_strobe_req) begin
            next_s.exec_valid = 1'b1;
            next_s.exec_code = host_strobe_code;
        end else if (s.pend_x) begin
            next_s.exec_valid = 1'b1;
            next_s.exec_code = binding_x_regs[7:0];
            take_x = 1'b1;
        end else if (s.pend_y) begin
            next_s.exec_valid = 1'b1;
            next_s.exec_code = binding_y_regs[7:0];
            take_y = 1'b1;
        end
        next_s.pend_x = hit_x | (s.pend_x & ~take_x);
        next_s.pend_y = hit_y | (s.pend_y & ~take_y);

        next_s.abort = ev[`ERB_EXC_BAD_ADDR] | ev[`ERB_EXC_CTX]
                     | ev[`ERB_EXC_OPERAND] | ev[`ERB_EXC_SPI];
    end

    // --------------------------------
    // state register
    // --------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign exception_flag_regs = s.flags;
    assign gpio_out = s.gpio;
    assign status_chan = s.chan;
    assign exec_valid = s.exec_valid;
    assign exec_code = s.exec_code;
    assign instr_abort = s.abort;

    // --------------------------------
    // checks
    // --------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_cs_rise_mid;
        s.cs_s2 && !s.cs_prev && lk.mid_byte;
    endsequence

    sequence seq_hit_x;
        hit_x ##1 !host_strobe_req;
    endsequence

    sequence seq_cs_rise_bound;
        s.cs_s2 && !s.cs_prev && !lk.mid_byte && fixed_len_instr
        && lk.byte_cnt != 8'h00 && lk.byte_cnt < operand_bytes;
    endsequence

    AST_FLAG_STICKY: assert property (
        |($past(exception_flag_regs) & ~exception_flag_regs) |-> $past(flag_wr_en))
        else $error("flag cleared without a write");

    AST_SET_WINS: assert property (
        |ev |=> ((exception_flag_regs & $past(ev)) == $past(ev)))
        else $error("raised flag not set");

    AST_HP_DONE: assert property (
        hp_done && !hp_failed |=> exception_flag_regs[`ERB_EXC_HP_DONE])
        else $error("processing done flag missing");

    AST_HP_FAIL: assert property (
        hp_done && hp_failed && !exception_flag_regs[`ERB_EXC_HP_DONE]
        |=> !exception_flag_regs[`ERB_EXC_HP_DONE])
        else $error("processing done flag on failure");

    AST_SPI_ERR: assert property (
        seq_cs_rise_mid |=> exception_flag_regs[`ERB_EXC_SPI] && instr_abort)
        else $error("broken transfer not flagged");

    AST_NOLOCK_FALL: assert property (
        s.lock_prev && !synth_lock && in_receive |=> exception_flag_regs[`ERB_EXC_NOLOCK])
        else $error("lock drop not flagged");

    AST_CH_B: assert property (
        ##1 status_chan[1] == |(exception_flag_regs & $past(mask_b)))
        else $error("channel b mismatch");

    AST_PIN_B: assert property (
        pin_config_reg[15:8] == `ERB_CFG_NCH_B |=> gpio_out[1] == |(exception_flag_regs & ~$past(mask_b)))
        else $error("complement b pin mismatch");

    AST_BIND_X: assert property (
        seq_hit_x |=> exec_valid && exec_code == $past(binding_x_regs[7:0]))
        else $error("x binding strobe missing");

    AST_RSVD: assert property (
        !exception_flag_regs[`ERB_EXC_RSVD])
        else $error("reserved flag set");

    AST_BAD_ADDR: assert property (
        bad_addr_hit |=> exception_flag_regs[`ERB_EXC_BAD_ADDR] && instr_abort)
        else $error("bad address not flagged");

    AST_CTX: assert property (
        ctx_violation |=> exception_flag_regs[`ERB_EXC_CTX] && instr_abort)
        else $error("context violation not flagged");

    AST_OPERAND: assert property (
        seq_cs_rise_bound |=> exception_flag_regs[`ERB_EXC_OPERAND] && instr_abort)
        else $error("malformed operand not flagged");

    AST_RX_ABORT: assert property (
        rx_abort && !exc_low_event[`ERB_EXC_RX_OVF] |=> exception_flag_regs[`ERB_EXC_RX_ABORT])
        else $error("reception abort not flagged");

    AST_CH_A: assert property (
        ##1 status_chan[0] == |(exception_flag_regs & $past(mask_a)))
        else $error("channel a mismatch");

    AST_SINGLE_PIN: assert property (
        pin_config_reg[7:0] == `ERB_CFG_EXC_LO |=> gpio_out[0] == exception_flag_regs[0])
        else $error("single flag pin mismatch");

    AST_RX_ERR_PIN: assert property (
        pin_config_reg[39:32] == `ERB_CFG_RX_ERR |=> gpio_out[4] == (exception_flag_regs[`ERB_EXC_RX_UNDF]
        | exception_flag_regs[`ERB_EXC_RX_OVF] | exception_flag_regs[`ERB_EXC_RX_ABORT]
        | exception_flag_regs[`ERB_EXC_MOVE_TO]))
        else $error("receive error pin mismatch");

    AST_GEN_ERR_PIN: assert property (
        pin_config_reg[47:40] == `ERB_CFG_GEN_ERR |=> gpio_out[5] == (exception_flag_regs[`ERB_EXC_BAD_ADDR]
        | exception_flag_regs[`ERB_EXC_CTX] | exception_flag_regs[`ERB_EXC_OPERAND]
        | exception_flag_regs[`ERB_EXC_SPI]))
        else $error("general error pin mismatch");

    AST_HOST_EXEC: assert property (
        host_strobe_req |=> exec_valid && exec_code == $past(host_strobe_code))
        else $error("host strobe not issued");

    AST_WR_ONE_KEEPS: assert property (
        flag_wr_en && flag_wr_sel == 2'h0
        |=> (exception_flag_regs[7:0] & $past(exception_flag_regs[7:0]) & $past(flag_wr_data))
            == ($past(exception_flag_regs[7:0]) & $past(flag_wr_data)))
        else $error("flag cleared by a one");
endmodule // erb_core

// >>> pkg/erb_defines.svh
// constants of the exception router and binder
`ifndef ERB_DEFINES_SVH
`define ERB_DEFINES_SVH
`define ERB_NFLAG 24
`define ERB_NPIN 6
`define ERB_EXC_RX_UNDF 5
`define ERB_EXC_RX_OVF 6
`define ERB_EXC_HP_DONE 15
`define ERB_EXC_BAD_ADDR 16
`define ERB_EXC_CTX 17
`define ERB_EXC_OPERAND 18
`define ERB_EXC_SPI 19
`define ERB_EXC_NOLOCK 20
`define ERB_EXC_RX_ABORT 21
`define ERB_EXC_MOVE_TO 22
`define ERB_EXC_RSVD 23
`define ERB_CFG_EXC_LO 8'h01
`define ERB_CFG_EXC_HI 8'h18
`define ERB_CFG_OFS 8'h01
`define ERB_CFG_CH_A 8'h21
`define ERB_CFG_CH_B 8'h22
`define ERB_CFG_NCH_A 8'h23
`define ERB_CFG_NCH_B 8'h24
`define ERB_CFG_RX_ERR 8'h25
`define ERB_CFG_GEN_ERR 8'h26
`define ERB_BIND_EN 15
`define ERB_BIND_EXC_HI 12
`define ERB_BIND_EXC_LO 8
`define ERB_CLK_PERIOD_NS 25
`define ERB_NOLOCK_NS 256000
`define ERB_MOVE_UNIT_NS 1000
`define ERB_LAST_BIT 3'h7
`endif

// >>> pkg/erb_pkg.sv
// types of the exception router and binder
package erb_pkg;
`include "erb_defines.svh"
    typedef logic [`ERB_NFLAG-1:0] erb_flag_t;
    typedef logic [7:0] erb_byte_t;
    typedef struct packed {
        logic [2:0] bit_cnt;
        erb_byte_t byte_cnt;
    } erb_link_s;
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_prev;
        erb_flag_t flags;
        erb_flag_t ev_prev;
        logic [`ERB_NPIN-1:0] gpio;
        logic [1:0] chan;
        logic lock_prev;
        logic rx_prev;
        logic nl_run;
        logic [15:0] nl_cnt;
        logic mv_run;
        logic [15:0] mv_cnt;
        logic pend_x;
        logic pend_y;
        logic exec_valid;
        erb_byte_t exec_code;
        logic abort;
    } erb_core_s;
endpackage

// >>> pkg/erb_link_if.sv
// serial frame state passed from the link clock domain
interface erb_link_if;
    logic mid_byte;
    logic [7:0] byte_cnt;
    modport link (output mid_byte, output byte_cnt);
    modport core (input mid_byte, input byte_cnt);
endinterface

// >>> rtl/erb_link_mon.sv
// serial bit and byte counter on the link clock
module erb_link_mon
    import erb_pkg::*;
(
    input wire logic spi_clk,
    input wire logic rst_n,
    input wire logic chip_select_n,
    erb_link_if.link lk
);
    erb_link_s s;
    erb_link_s next_s;
    logic fresh;

    // --------------------------------
    // counting
    // --------------------------------
    always_comb begin
        next_s = s;
        if (fresh) begin
            next_s.bit_cnt = 3'h1;
            next_s.byte_cnt = 8'h00;
        end else begin
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == `ERB_LAST_BIT && s.byte_cnt != 8'hff) begin
                next_s.byte_cnt = s.byte_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge spi_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // frame start marker, armed while select is high
    always_ff @(posedge spi_clk or posedge chip_select_n) begin
        if (chip_select_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // counts stay frozen after the frame until the next first edge
    assign lk.mid_byte = (s.bit_cnt != 3'h0);
    assign lk.byte_cnt = s.byte_cnt;
endmodule // erb_link_mon

// >>> sim/erb_host_model.sv
// host serial model: select and link clock
module erb_host_model (
    output logic spi_clk,
    output logic chip_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_clk = 1'b0;
        chip_select_n = 1'b1;
    end
    // ------------------------------------
    // frame of n clock pulses, clock still outside frames
    // ------------------------------------
    task automatic frame(input int n);
        #7;
        chip_select_n = 1'b0;
        #40;
        repeat (n) begin
            spi_clk = 1'b1;
            #40;
            spi_clk = 1'b0;
            #40;
        end
        chip_select_n = 1'b1;
    endtask
endmodule // erb_host_model

// >>> sim/tb_exception_router_and_binder.sv
// self-checking bench of the exception router and binder
module tb_exception_router_and_binder;
    timeunit 1ns;
    timeprecision 1ps;
    import erb_pkg::*;
    logic core_clk, rst_n, spi_clk, chip_select_n, hp_done, hp_failed, bad_addr_hit, ctx_violation;
    logic fixed_len_instr, in_receive, synth_lock, rx_abort, rx_move_start, rx_move_short;
    logic flag_wr_en, host_strobe_req, exec_valid, instr_abort;
    logic [14:0] exc_low_event;
    erb_byte_t operand_bytes, receive_move_wait_setting, flag_wr_data, host_strobe_code;
    logic [1:0] flag_wr_sel, status_chan;
    erb_flag_t mask_a, mask_b;
    logic [47:0] pin_config_reg;
    logic [15:0] binding_x_regs, binding_y_regs;
    logic [23:0] exception_flag_regs;
    logic [5:0] gpio_out;
    logic [7:0] exec_code;
    int err_total, n_checks, cyc, n;
    logic [7:0] c;
    erb_core #(.NOLOCK_CYC(20)) dut_u (.core_clk, .rst_n, .spi_clk, .chip_select_n, .exc_low_event,
        .hp_done, .hp_failed, .bad_addr_hit, .ctx_violation, .fixed_len_instr, .operand_bytes,
        .in_receive, .synth_lock, .rx_abort, .rx_move_start, .rx_move_short, .receive_move_wait_setting,
        .flag_wr_en, .flag_wr_sel, .flag_wr_data, .mask_a, .mask_b, .pin_config_reg, .binding_x_regs,
        .binding_y_regs, .host_strobe_req, .host_strobe_code, .exception_flag_regs, .gpio_out,
        .status_chan, .exec_valid, .exec_code, .instr_abort);
    erb_host_model host_u (.spi_clk, .chip_select_n);
    always #12.5 core_clk = ~core_clk;
    // ------------------------------------
    // helpers
    // ------------------------------------
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up;
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic set(input int k, input logic v);
        case (k)
            15: hp_done <= v;
            16: bad_addr_hit <= v;
            17: ctx_violation <= v;
            21: rx_abort <= v;
            default: exc_low_event[k] <= v;
        endcase
    endtask
    task automatic fire(input int k);
        @(posedge core_clk);
        set(k, 1'b1);
        @(posedge core_clk);
        set(k, 1'b0);
        #1;
    endtask
    task automatic wr(input int s, input erb_byte_t d);
        @(posedge core_clk);
        flag_wr_en <= 1'b1;
        flag_wr_sel <= 2'(s);
        flag_wr_data <= d;
        @(posedge core_clk);
        flag_wr_en <= 1'b0;
        #1;
    endtask
    task automatic clr_all;
        for (int i = 0; i < 3; i++) begin
            wr(i, 8'h00);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic watch(output int cnt, output logic [7:0] code);
        cnt = 0;
        code = 8'h00;
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            if (i == 0) host_strobe_req <= 1'b0;
            if (i == 2) exc_low_event <= 15'h0000;
            #1;
            if (exec_valid === 1'b1) begin
                cnt++;
                code = exec_code;
            end
        end
    endtask
    // ------------------------------------
    // scenarios
    // ------------------------------------
    task automatic t_flags;
        @(posedge core_clk);
        pin_config_reg <= {40'h0, 8'h01};
        fire(0);
        chk("pin0", 24'h000001, 24'(gpio_out));
        wr(0, 8'hff);
        chk("flag kept", 24'h000001, exception_flag_regs);
        wr(0, 8'hfe);
        for (int k = 0; k < 22; k++) begin
            if (k < 18 || k == 21) begin
                fire(k);
                chk("flag bit", 24'h000001 << k, exception_flag_regs);
                wr(k / 8, ~(8'h01 << (k % 8)));
                chk("flag clr", 24'h000000, exception_flag_regs);
            end
        end
    endtask
    task automatic t_edges;
        fire(3);
        @(posedge core_clk);
        exc_low_event[3] <= 1'b1;
        flag_wr_en <= 1'b1;
        flag_wr_sel <= 2'h0;
        flag_wr_data <= 8'hf7;
        @(posedge core_clk);
        exc_low_event[3] <= 1'b0;
        flag_wr_en <= 1'b0;
        #1;
        chk("clear race", 24'h000008, exception_flag_regs);
        clr_all();
        hp_failed <= 1'b1;
        fire(15);
        hp_failed <= 1'b0;
        chk("hp failed", 24'h000000, exception_flag_regs);
        fire(16);
        chk("abort", 24'h000001, 24'(instr_abort));
        clr_all();
        @(posedge core_clk);
        exc_low_event[6] <= 1'b1;
        rx_abort <= 1'b1;
        fire(6);
        rx_abort <= 1'b0;
        chk("ovf abort", 24'h000040, exception_flag_regs);
        clr_all();
    endtask
    task automatic t_chan;
        @(posedge core_clk);
        mask_b <= 24'h000021;
        mask_a <= 24'h010000;
        pin_config_reg <= {8'h26, 8'h25, 8'h23, 8'h21, 8'h24, 8'h22};
        fire(5);
        chk("chan pins", 24'h000019, 24'(gpio_out));
        chk("status", 24'h000002, 24'(status_chan));
        clr_all();
        fire(16);
        chk("chan pins", 24'h000026, 24'(gpio_out));
        chk("status", 24'h000001, 24'(status_chan));
        clr_all();
    endtask
    task automatic t_bind;
        @(posedge core_clk);
        binding_x_regs <= 16'h8906;
        binding_y_regs <= 16'h8a0c;
        exc_low_event[9] <= 1'b1;
        watch(n, c);
        chk("bind x", 24'h000106, {8'h0, 8'(n), c});
        @(posedge core_clk);
        exc_low_event[10] <= 1'b1;
        watch(n, c);
        chk("bind y", 24'h00010c, {8'h0, 8'(n), c});
        @(posedge core_clk);
        exc_low_event[9] <= 1'b1;
        host_strobe_req <= 1'b1;
        host_strobe_code <= 8'h33;
        watch(n, c);
        chk("host and x", 24'h000002, 24'(n));
        @(posedge core_clk);
        binding_x_regs <= 16'h0906;
        exc_low_event[9] <= 1'b1;
        watch(n, c);
        chk("bind off", 24'h000000, 24'(n));
        clr_all();
    endtask
    task automatic t_spi;
        @(posedge core_clk);
        fixed_len_instr <= 1'b1;
        operand_bytes <= 8'h03;
        host_u.frame(5);
        tick(8);
        chk("mid byte", 24'h080000, exception_flag_regs);
        clr_all();
        host_u.frame(8);
        tick(8);
        chk("short op", 24'h040000, exception_flag_regs);
        clr_all();
        host_u.frame(24);
        tick(8);
        chk("full op", 24'h000000, exception_flag_regs);
    endtask
    task automatic t_lock;
        @(posedge core_clk);
        in_receive <= 1'b1;
        tick(15);
        chk("lock wait", 24'h000000, exception_flag_regs);
        tick(10);
        chk("no lock", 24'h100000, exception_flag_regs);
        synth_lock <= 1'b1;
        clr_all();
        chk("locked", 24'h000000, exception_flag_regs);
        @(posedge core_clk);
        synth_lock <= 1'b0;
        tick(3);
        chk("lock drop", 24'h100000, exception_flag_regs);
        in_receive <= 1'b0;
        clr_all();
        @(posedge core_clk);
        receive_move_wait_setting <= 8'h01;
        rx_move_short <= 1'b1;
        fire(13);
        rx_move_start <= 1'b1;
        tick(1);
        rx_move_start <= 1'b0;
        tick(30);
        chk("move wait", 24'h002000, exception_flag_regs);
        tick(20);
        chk("move out", 24'h402000, exception_flag_regs);
    endtask
    initial begin
        {core_clk, rst_n, exc_low_event, hp_done, hp_failed, bad_addr_hit, ctx_violation} = '0;
        {fixed_len_instr, operand_bytes, in_receive, synth_lock, rx_abort, rx_move_start} = '0;
        {rx_move_short, receive_move_wait_setting, flag_wr_en, flag_wr_sel, flag_wr_data} = '0;
        {mask_a, mask_b, pin_config_reg, binding_x_regs, binding_y_regs} = '0;
        {host_strobe_req, host_strobe_code, err_total, n_checks, cyc} = '0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        tick(2);
        t_flags();
        t_edges();
        t_chan();
        t_bind();
        t_spi();
        t_lock();
        wrap_up();
    end
endmodule // tb_exception_router_and_binder
